/* design/spi_pkg.sv */
package spi_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [3:0] idx_ccr = 4'h0;
  localparam logic [3:0] idx_ctl = 4'h1;
  localparam logic [3:0] idx_sts = 4'h2;
  localparam logic [3:0] idx_brr = 4'h4;
  localparam logic [3:0] idx_emu = 4'h6;
  localparam logic [3:0] idx_buf = 4'h7;
  localparam logic [3:0] idx_dat = 4'h9;
  localparam logic [3:0] idx_pc1 = 4'hd;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ccr_swrst = 7;
  localparam int ccr_pol = 6;
  localparam int ctl_ovr_ie = 4;
  localparam int ctl_phase = 3;
  localparam int ctl_master = 2;
  localparam int ctl_talk = 1;
  localparam int ctl_int_ie = 0;
  localparam int sts_ovr = 7;
  localparam int sts_int = 6;
  localparam int pc1_ste_in = 7;
  localparam int pc1_ste_out = 6;
  localparam int pc1_ste_fn = 5;
  localparam int pc1_ste_dir = 4;

  // ----------------------------------------------------------------
  // writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ccr_wmask = 8'hc7;
  localparam logic [7:0] ctl_wmask = 8'h1f;
  localparam logic [7:0] brr_wmask = 8'h7f;
  localparam logic [7:0] pc1_wmask = 8'h70;
  localparam logic [7:0] reg_rst = 8'h00;

  // ----------------------------------------------------------------
  // bit rate
  // ----------------------------------------------------------------
  localparam logic [6:0] brr_min = 7'h03;
  localparam logic [7:0] div_floor = 8'h04;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_lead = 2'b01,
    st_trail = 2'b11
  } shift_state_e;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ste;
  } pin_in_s;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ste_o;
    logic ste_oe;
  } pin_out_s;

endpackage

/* design/spi_core.sv */
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module spi_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire spi_pkg::pin_in_s pins_in,
  output spi_pkg::pin_out_s pins_out,
  // system
  input wire logic idle_powerdown,
  output logic irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ccr_q;
  logic [7:0] ctl_q;
  logic [7:0] brr_q;
  logic [7:0] pc1_q;
  logic [7:0] dat;
  logic [7:0] rx_buf;
  logic int_flag;
  logic overrun;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sclk_prev;
  spi_pkg::pin_in_s pin_s;
  spi_pkg::shift_state_e state;
  logic [7:0] cnt;
  logic [2:0] bitcnt;
  logic sample;
  logic out_bit;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  genvar g;
  for (g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1[g] <= 1'b0;
        sync2[g] <= 1'b0;
      end else begin
        sync1[g] <= pins_in[g];
        sync2[g] <= sync1[g];
      end
    end
  end
  assign pin_s = spi_pkg::pin_in_s'(sync2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= pin_s.sclk;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [3:0] idx;
  logic mapped;
  logic acc;
  logic wr;
  logic rd_buf;
  logic [7:0] rdata;
  assign idx = paddr[5:2];
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && mapped;
  assign rd_buf = acc && !pwrite && mapped && idx == spi_pkg::idx_buf;

  always_comb begin
    mapped = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
    rdata = 8'h00;
    unique case (idx)
      spi_pkg::idx_ccr: rdata = ccr_q;
      spi_pkg::idx_ctl: rdata = ctl_q;
      spi_pkg::idx_sts: rdata = {overrun, int_flag, 6'h00};
      spi_pkg::idx_brr: rdata = brr_q;
      spi_pkg::idx_emu: rdata = rx_buf;
      spi_pkg::idx_buf: rdata = rx_buf;
      spi_pkg::idx_dat: rdata = dat;
      spi_pkg::idx_pc1: rdata = {pin_s.ste, pc1_q[6:0]};
      default: mapped = 1'b0;
    endcase
  end

  // one wait-free answer: ready rises in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata <= mapped ? {24'h00_0000, rdata} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic swrst;
  logic pol;
  logic phase;
  logic master;
  logic talk;
  logic [2:0] len;
  assign swrst = ccr_q[spi_pkg::ccr_swrst];
  assign pol = ccr_q[spi_pkg::ccr_pol];
  assign len = ccr_q[2:0];
  assign phase = ctl_q[spi_pkg::ctl_phase];
  assign master = ctl_q[spi_pkg::ctl_master];
  assign talk = ctl_q[spi_pkg::ctl_talk];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_q <= spi_pkg::reg_rst;
      ctl_q <= spi_pkg::reg_rst;
      brr_q <= spi_pkg::reg_rst;
      pc1_q <= spi_pkg::reg_rst;
    end else if (wr) begin
      if (idx == spi_pkg::idx_ccr) ccr_q <= pwdata[7:0] & spi_pkg::ccr_wmask;
      if (idx == spi_pkg::idx_ctl) ctl_q <= pwdata[7:0] & spi_pkg::ctl_wmask;
      if (idx == spi_pkg::idx_brr) brr_q <= pwdata[7:0] & spi_pkg::brr_wmask;
      if (idx == spi_pkg::idx_pc1) pc1_q <= pwdata[7:0] & spi_pkg::pc1_wmask;
    end
  end

  // ----------------------------------------------------------------
  // bit-rate divider and master clock sequencer
  // ----------------------------------------------------------------
  logic [7:0] div;
  logic [7:0] lead_len;
  logic [7:0] trail_len;
  logic start;
  logic m_e1;
  logic m_e2;
  logic last_bit;
  assign div = (brr_q[6:0] < spi_pkg::brr_min) ? spi_pkg::div_floor
             : brr_q + 8'h01;
  // idle-level half takes the odd clock
  assign trail_len = {1'b0, div[7:1]};
  assign lead_len = div - trail_len;
  assign start = wr && idx == spi_pkg::idx_dat && master && !swrst
               && state == spi_pkg::st_idle;
  assign m_e1 = state == spi_pkg::st_lead && cnt == 8'h00;
  assign m_e2 = state == spi_pkg::st_trail && cnt == 8'h00;
  assign last_bit = bitcnt == len;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spi_pkg::st_idle;
      cnt <= 8'h00;
    end else if (swrst || !master) begin
      state <= spi_pkg::st_idle;
      cnt <= 8'h00;
    end else begin
      unique case (state)
        spi_pkg::st_idle: if (start) begin
          state <= spi_pkg::st_lead;
          cnt <= lead_len - 8'h01;
        end
        spi_pkg::st_lead: if (cnt == 8'h00) begin
          state <= spi_pkg::st_trail;
          cnt <= trail_len - 8'h01;
        end else begin
          cnt <= cnt - 8'h01;
        end
        spi_pkg::st_trail: if (cnt == 8'h00) begin
          state <= last_bit ? spi_pkg::st_idle : spi_pkg::st_lead;
          cnt <= lead_len - 8'h01;
        end else begin
          cnt <= cnt - 8'h01;
        end
        default: state <= spi_pkg::st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // edge selection and shifter
  // ----------------------------------------------------------------
  logic sel_ok;
  logic s_e1;
  logic s_e2;
  logic e1;
  logic e2;
  logic rx_in;
  logic char_done;
  logic [7:0] shift_val;
  // strobe only gates a slave; high stops the shifter
  assign sel_ok = master || !pc1_q[spi_pkg::pc1_ste_fn] || !pin_s.ste;
  // slave edges need the external clock at least a divide by eight
  assign s_e1 = !master && sel_ok && sclk_prev == pol
              && pin_s.sclk != pol;
  assign s_e2 = !master && sel_ok && sclk_prev != pol
              && pin_s.sclk == pol;
  assign e1 = !swrst && (master ? m_e1 : s_e1);
  assign e2 = !swrst && (master ? m_e2 : s_e2);
  assign rx_in = master ? pin_s.miso : pin_s.mosi;
  assign char_done = e2 && last_bit;
  // with delay the bit was taken at the first edge
  assign shift_val = {dat[6:0], phase ? sample : rx_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcnt <= 3'h0;
    end else if (swrst) begin
      bitcnt <= 3'h0;
    end else if (e2) begin
      bitcnt <= last_bit ? 3'h0 : bitcnt + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample <= 1'b0;
    end else if (e1) begin
      sample <= rx_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat <= 8'h00;
    end else if (wr && idx == spi_pkg::idx_dat && state == spi_pkg::st_idle) begin
      dat <= pwdata[7:0];
    end else if (e2) begin
      dat <= shift_val;
    end
  end

  // output bit: half ahead with delay, at the first edge without
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_bit <= 1'b0;
    end else if (phase) begin
      if (wr && idx == spi_pkg::idx_dat && state == spi_pkg::st_idle) begin
        out_bit <= pwdata[7];
      end else if (e2) begin
        out_bit <= shift_val[7];
      end
    end else if (e1) begin
      out_bit <= dat[7];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf <= 8'h00;
    end else if (char_done) begin
      rx_buf <= shift_val;
    end
  end

  // ----------------------------------------------------------------
  // status flags and interrupt
  // ----------------------------------------------------------------
  logic ovr_clr;
  assign ovr_clr = wr && idx == spi_pkg::idx_sts && pwdata[spi_pkg::sts_ovr];

  // a completion in the read cycle wins over the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flag <= 1'b0;
    end else if (swrst || idle_powerdown) begin
      int_flag <= 1'b0;
    end else if (char_done) begin
      int_flag <= 1'b1;
    end else if (rd_buf) begin
      int_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (swrst) begin
      overrun <= 1'b0;
    end else if (char_done && int_flag) begin
      overrun <= 1'b1;
    end else if (ovr_clr) begin
      overrun <= 1'b0;
    end
  end

  // level request: masking never loses a pending flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (int_flag && ctl_q[spi_pkg::ctl_int_ie])
           || (overrun && ctl_q[spi_pkg::ctl_ovr_ie]);
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_out <= '0;
    end else begin
      pins_out.sclk_o <= (state == spi_pkg::st_trail) ^ pol;
      pins_out.sclk_oe <= master;
      pins_out.mosi_o <= out_bit;
      pins_out.mosi_oe <= master && talk;
      pins_out.miso_o <= out_bit;
      pins_out.miso_oe <= !master && talk && sel_ok;
      pins_out.ste_o <= pc1_q[spi_pkg::pc1_ste_out];
      pins_out.ste_oe <= pc1_q[spi_pkg::pc1_ste_dir]
        && (master || !pc1_q[spi_pkg::pc1_ste_fn]);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence start_seq;
    start ##1 state == spi_pkg::st_lead;
  endsequence

  xfer_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |-> start_seq)
    else $error("master write did not start a transfer");

  buf_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    char_done && !idle_powerdown |=> rx_buf == $past(shift_val) && int_flag)
    else $error("receive buffer or flag not loaded");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    int_flag && !rd_buf && !swrst && !idle_powerdown |=> int_flag)
    else $error("completion flag dropped");

  ovr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    char_done && int_flag && !swrst |=> overrun)
    else $error("overrun not flagged");

  ovr_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    overrun && !ovr_clr && !swrst |=> overrun)
    else $error("overrun cleared without software");

  irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctl_q[spi_pkg::ctl_int_ie]) && int_flag ##1 int_flag |-> irq)
    else $error("interrupt not reasserted");

  miso_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !talk |=> !pins_out.miso_oe && !pins_out.mosi_oe)
    else $error("output driven while transmit disabled");

  ste_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !master && pc1_q[spi_pkg::pc1_ste_fn] && pin_s.ste |-> !e1 && !e2)
    else $error("slave shifted while deselected");

  clk_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == spi_pkg::st_trail |=> pins_out.sclk_o == !$past(pol))
    else $error("serial clock level wrong");

  lead_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> cnt == $past(lead_len) - 8'h01)
    else $error("idle half length wrong");

  swrst_a: assert property (@(posedge pclk) disable iff (!presetn)
    swrst |=> !int_flag && !overrun && bitcnt == 3'h0)
    else $error("software reset left flags set");

endmodule

/* tb/spi_peer.sv */
`timescale 1ns/1ps
module spi_peer (
  // system clock
  input wire logic pclk,
  // wire levels
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ste,
  // scheme and role
  input wire logic pol,
  input wire logic pha,
  input wire logic [3:0] nbits,
  input wire logic master_role,
  // levels driven back
  output logic sclk_d,
  output logic mosi_d,
  output logic miso_d,
  output logic ste_d
);
  // ------------
  // shifter
  // ------------
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic [3:0] ocnt = 4'h0;
  logic last = 1'b0;
  logic bit_o;

  // as clock source the next bit moves on the drive edge, away from capture
  assign bit_o = tx[3'(7 - (master_role ? ocnt : cnt))];
  // released lines move every cycle so no stale bit can pass for data
  assign mosi_d = master_role ? bit_o : ~last;
  assign miso_d = (master_role || ste) ? ~last : bit_o;

  initial begin
    sclk_d = 1'b0;
    ste_d = 1'b1;
  end

  always @(posedge pclk) begin
    last <= ~last;
  end

  // capture on trailing edge without delay, leading edge with it
  always @(sclk) begin
    if (ste === 1'b0 && ((sclk !== pol) == pha)) begin
      rx = {rx[6:0], master_role ? miso : mosi};
      cnt = cnt + 4'h1;
    end else if (ste === 1'b0) begin
      ocnt = cnt;
    end
  end

  task automatic load(input logic [7:0] d);
    tx = d;
    rx = 8'h00;
    cnt = 4'h0;
    ocnt = 4'h0;
  endtask

  // ------------
  // clock source
  // ------------
  // sixteen system clocks a bit leaves margin for the pin synchronisers
  task automatic clock_out(input logic [7:0] d);
    load(d);
    @(posedge pclk);
    sclk_d <= pol;
    ste_d <= 1'b0;
    repeat (8) @(posedge pclk);
    repeat (2 * nbits) begin
      sclk_d <= ~sclk_d;
      repeat (8) @(posedge pclk);
    end
    ste_d <= 1'b1;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  // ------------
  // signals
  // ------------
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic idle_powerdown;
  logic irq;
  spi_pkg::pin_in_s pins_in;
  spi_pkg::pin_out_s pins_out;
  logic p_sclk;
  logic p_mosi;
  logic p_miso;
  logic p_ste;
  logic pol = 1'b0;
  logic pha = 1'b0;
  logic peer_drives = 1'b0;
  logic [3:0] nbits = 4'h8;
  logic [7:0] rdata;
  logic rerr;
  int dv;
  int mismatches = 0;
  int n_checks = 0;
  logic [7:0] brr_t [5] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h7f};

  assign pins_in = {pins_out.sclk_oe ? pins_out.sclk_o : p_sclk,
                    pins_out.mosi_oe ? pins_out.mosi_o : p_mosi,
                    pins_out.miso_oe ? pins_out.miso_o : p_miso,
                    pins_out.ste_oe ? pins_out.ste_o : p_ste};

  spi_core spi_core_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .pins_out(pins_out),
    .idle_powerdown(idle_powerdown), .irq(irq));

  spi_peer spi_peer_i (.pclk(pclk), .sclk(pins_in.sclk),
    .mosi(pins_in.mosi), .miso(pins_in.miso), .ste(pins_in.ste),
    .pol(pol), .pha(pha), .nbits(nbits), .master_role(peer_drives),
    .sclk_d(p_sclk), .mosi_d(p_mosi), .miso_d(p_miso), .ste_d(p_ste));

  // ------------
  // tasks
  // ------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  // one idle cycle between transfers keeps psel from two writes at once
  task automatic apb(input logic [3:0] idx, input logic wr,
                     input logic [7:0] wd);
    int n;
    @(posedge pclk);
    paddr <= {2'b00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h000000, wd};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
    rdata = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [7:0] e,
                     input string w);
    apb(idx, 1'b0, 8'h00);
    chk(w, 16'(e), 16'(rdata));
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge pclk);
    chk("irq", 16'(e), 16'(irq));
  endtask

  task automatic cfg(input logic [7:0] ccr, input logic [7:0] ctl,
                     input logic [7:0] brr);
    wr(spi_pkg::idx_ccr, ccr | 8'h80);
    wr(spi_pkg::idx_ctl, ctl);
    wr(spi_pkg::idx_brr, brr);
    wr(spi_pkg::idx_ccr, ccr);
    pol = ccr[6];
    pha = ctl[3];
    nbits = 4'(ccr[2:0]) + 4'h1;
    dv = (brr < 8'h03) ? 4 : int'(brr) + 1;
  endtask

  // master transfer with clock shape measured on the pin
  task automatic xfer(input logic [7:0] d, input logic [7:0] p,
                      input bit rd_back);
    int n;
    int k;
    int a;
    int first;
    int last;
    int ends;
    logic prev;
    logic [15:0] e;
    spi_pkg::pin_out_s po;
    spi_peer_i.load(p);
    e = ({8'h00, d} << nbits) | 16'(p >> (8 - nbits));
    wr(spi_pkg::idx_pc1, 8'h30);
    wr(spi_pkg::idx_dat, d);
    po = pins_out;
    chk("pin drive", 16'({pol, 4'b1101}), 16'({po.sclk_o, po.sclk_oe,
        po.mosi_oe, po.ste_o, po.ste_oe}));
    n = 0;
    a = 0;
    first = 0;
    last = 0;
    ends = 0;
    prev = 1'b0;
    while (ends < int'(nbits) && n < 3000) begin
      @(posedge pclk);
      n++;
      if (pins_out.sclk_o !== pol) begin
        a++;
        if (first == 0) first = n;
        last = n;
      end else if (prev) ends++;
      prev = (pins_out.sclk_o !== pol);
    end
    k = 0;
    rdata = 8'h00;
    while (rdata[6] !== 1'b1 && k < 20) begin
      apb(spi_pkg::idx_sts, 1'b0, 8'h00);
      k++;
    end
    if (n >= 3000 || k >= 20) begin
      mismatches++;
      close_out();
    end
    chk("active clocks", 16'(nbits * (dv / 2)), 16'(a));
    chk("span", 16'((nbits - 1) * dv + dv / 2), 16'(last - first + 1));
    chk("idle clock", 16'(pol), 16'(pins_out.sclk_o));
    chk("peer rx", 16'(d >> (8 - nbits)), 16'(spi_peer_i.rx));
    if (rd_back) begin
      rdc(spi_pkg::idx_emu, e[7:0], "emu");
      rdc(spi_pkg::idx_sts, 8'h40, "sts after emu");
      rdc(spi_pkg::idx_buf, e[7:0], "buf");
      rdc(spi_pkg::idx_sts, 8'h00, "sts after buf");
    end
    wr(spi_pkg::idx_pc1, 8'h70);
  endtask

  // ------------
  // sequence
  // ------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    close_out();
  end

  initial begin
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    idle_powerdown = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(spi_pkg::idx_ccr, 8'h00, "ccr reset");
    rdc(spi_pkg::idx_ctl, 8'h00, "ctl reset");
    rdc(spi_pkg::idx_sts, 8'h00, "sts reset");
    rdc(spi_pkg::idx_brr, 8'h00, "brr reset");
    rdc(4'h3, 8'h00, "unmapped data");
    chk("unmapped err", 16'h0001, 16'(rerr));
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      cfg({1'b0, i[1], 6'h07}, {4'h0, i[0], 3'b110}, brr_t[i]);
      xfer(8'ha5 ^ 8'(i), 8'h3c + 8'(i), 1'b1);
    end
    $display("test schemes and rates done");
    cfg(8'h04, 8'h06, 8'h03);
    xfer(8'h58, 8'hd0, 1'b1);
    xfer(8'h6c, 8'h4c, 1'b1);
    cfg(8'h00, 8'h06, 8'h03);
    xfer(8'h80, 8'h80, 1'b1);
    $display("test short characters done");
    cfg(8'h07, 8'h07, 8'h03);
    xfer(8'hc3, 8'h81, 1'b0);
    irq_is(1'b1);
    wr(spi_pkg::idx_ctl, 8'h06);
    irq_is(1'b0);
    wr(spi_pkg::idx_ctl, 8'h07);
    irq_is(1'b1);
    wr(spi_pkg::idx_ctl, 8'h16);
    xfer(8'h3c, 8'h7e, 1'b0);
    rdc(spi_pkg::idx_sts, 8'hc0, "sts overrun");
    irq_is(1'b1);
    rdc(spi_pkg::idx_buf, 8'h7e, "buf overwritten");
    rdc(spi_pkg::idx_sts, 8'h80, "overrun kept");
    irq_is(1'b1);
    wr(spi_pkg::idx_sts, 8'h80);
    rdc(spi_pkg::idx_sts, 8'h00, "overrun cleared");
    irq_is(1'b0);
    $display("test flags done");
    xfer(8'h11, 8'h22, 1'b0);
    @(posedge pclk);
    idle_powerdown <= 1'b1;
    @(posedge pclk);
    idle_powerdown <= 1'b0;
    rdc(spi_pkg::idx_sts, 8'h00, "sts power down");
    xfer(8'h33, 8'h44, 1'b0);
    wr(spi_pkg::idx_ccr, 8'h87);
    rdc(spi_pkg::idx_sts, 8'h00, "sts soft reset");
    rdc(spi_pkg::idx_ccr, 8'h87, "ccr kept");
    $display("test clearing done");
    cfg(8'h07, 8'h02, 8'h03);
    wr(spi_pkg::idx_pc1, 8'h20);
    wr(spi_pkg::idx_dat, 8'h96);
    repeat (2) @(posedge pclk);
    chk("miso deselected", 16'h0000, 16'(pins_out.miso_oe));
    peer_drives = 1'b1;
    spi_peer_i.clock_out(8'h5a);
    peer_drives = 1'b0;
    chk("peer rx slave", 16'h0096, 16'(spi_peer_i.rx));
    rdc(spi_pkg::idx_buf, 8'h5a, "slave buf");
    wr(spi_pkg::idx_pc1, 8'h00);
    repeat (2) @(posedge pclk);
    chk("miso plain io", 16'h0001, 16'(pins_out.miso_oe));
    wr(spi_pkg::idx_ctl, 8'h00);
    repeat (2) @(posedge pclk);
    chk("miso talk off", 16'h0000, 16'(pins_out.miso_oe));
    $display("test slave done");
    close_out();
  end
endmodule
